// *** rtl/rfcs_pkg.sv ***
package rfcs_pkg;

    // Counter geometry, both counters share it
    localparam int RFCS_CNT_W = 24;
    localparam logic [RFCS_CNT_W-1:0] RFCS_CNT_ZERO = 24'h000000;
    localparam logic [RFCS_CNT_W-1:0] RFCS_CNT_ONE = 24'h000001;
    localparam logic [RFCS_CNT_W-1:0] RFCS_CNT_ONES = 24'hffffff;

    // Sequencer phases
    typedef enum logic [1:0] {
        RFCS_IDLE,
        RFCS_REF,
        RFCS_SENSOR_A,
        RFCS_SENSOR_B
    } rfcs_phase_type;

    // Start bits of the oscillation trigger register
    typedef struct packed {
        logic reference_start_bit;
        logic sensor_a_start_bit;
        logic sensor_b_start_bit;
    } rfcs_trig_type;

    // Event flag register fields
    typedef struct packed {
        logic reference_done_flag;
        logic sensor_a_done_flag;
        logic sensor_b_done_flag;
        logic measure_overflow_flag;
        logic time_base_overflow_flag;
    } rfcs_flags_type;

    localparam rfcs_trig_type RFCS_TRIG_RESET = 3'h0;
    localparam rfcs_flags_type RFCS_FLAGS_RESET = 5'h00;

endpackage : rfcs_pkg

// *** rtl/rfcs_sync_edge.sv ***
`timescale 1ns/100ps

// Two-flop synchroniser with rising edge detect behind it
module rfcs_sync_edge
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic async_in,
    output logic level_out,
    output logic rise_out
);

    typedef struct packed {
        logic meta;
        logic stable;
        logic prev;
    } rfcs_sync_state_type;

    rfcs_sync_state_type state_reg;
    rfcs_sync_state_type state_next;

    // First flop feeds only the second; edge taken on later stages
    always_comb
    begin
        state_next = state_reg;
        state_next.meta = async_in;
        state_next.stable = state_reg.meta;
        state_next.prev = state_reg.stable;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= 3'h0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign level_out = state_reg.stable;
    assign rise_out = state_reg.stable & ~state_reg.prev;

endmodule : rfcs_sync_edge

// *** rtl/rfcs_counter.sv ***
`timescale 1ns/100ps

// Presettable up/down counter with wrap and zero-reach strobes
module rfcs_counter
#(
    parameter int W = rfcs_pkg::RFCS_CNT_W
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic load,
    input wire logic [W-1:0] load_value,
    input wire logic count_up,
    input wire logic count_down,
    output logic [W-1:0] value,
    output logic wrap_up,
    output logic reach_zero
);

    typedef struct packed {
        logic [W-1:0] cnt;
    } rfcs_cnt_state_type;

    rfcs_cnt_state_type state_reg;
    rfcs_cnt_state_type state_next;

    // Preset wins over counting
    always_comb
    begin
        state_next = state_reg;
        if (load)
        begin
            state_next.cnt = load_value;
        end
        else if (count_up)
        begin
            state_next.cnt = W'(state_reg.cnt + 1'b1);
        end
        else if (count_down)
        begin
            state_next.cnt = W'(state_reg.cnt - 1'b1);
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign value = state_reg.cnt;
    // All ones stepping to zero, and one stepping down to zero
    assign wrap_up = count_up & ~load & (state_reg.cnt == {W{1'b1}});
    assign reach_zero = count_down & ~load & (state_reg.cnt == W'(1));

endmodule : rfcs_counter

// *** rtl/rfcs_core.sv ***
`timescale 1ns/100ps

module rfcs_core
#(
    parameter int CNT_W = rfcs_pkg::RFCS_CNT_W
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic converter_enable,
    input wire logic continuous_oscillation_enable,
    input wire logic event_counter_select,
    input wire logic osc_clk_in,
    input wire logic event_clk_in,
    input wire logic divided_operating_clock,
    input wire logic trig_wr,
    input wire rfcs_pkg::rfcs_trig_type trig_wdata,
    input wire logic mc_wr,
    input wire logic [CNT_W-1:0] mc_wdata,
    input wire logic tc_wr,
    input wire logic [CNT_W-1:0] tc_wdata,
    input wire logic flag_clr,
    input wire rfcs_pkg::rfcs_flags_type flag_clr_mask,
    input wire rfcs_pkg::rfcs_flags_type flag_irq_enable,
    output rfcs_pkg::rfcs_trig_type trig_status,
    output rfcs_pkg::rfcs_flags_type flags,
    output logic [CNT_W-1:0] measurement_counter,
    output logic [CNT_W-1:0] time_base_counter,
    output logic osc_clk_monitor,
    output logic irq
);

    typedef struct packed {
        rfcs_pkg::rfcs_phase_type phase;
        rfcs_pkg::rfcs_trig_type trig;
        rfcs_pkg::rfcs_flags_type flags;
        logic monitor;
    } rfcs_core_state_type;

    rfcs_core_state_type state_reg;
    rfcs_core_state_type state_next;

    logic count_src;
    logic src_level;
    logic src_rise;
    logic tb_rise;
    logic running;
    logic in_ref;
    logic in_sensor;
    logic mc_up;
    logic tc_up;
    logic tc_down;
    logic tc_load;
    logic [CNT_W-1:0] tc_load_value;
    logic mc_wrap;
    logic tc_wrap;
    logic tc_reach_zero;
    logic tc_is_zero;
    logic start_ref;
    logic start_a;
    logic start_b;
    logic abort_req;
    logic ref_mc_end;
    logic ref_tc_end;
    logic sen_tc_end;
    logic sen_mc_end;
    logic auto_stop;
    rfcs_pkg::rfcs_flags_type flag_set;
    rfcs_pkg::rfcs_flags_type flag_keep;

    // Counting source: internal oscillator or external pulses
    assign count_src = event_counter_select ? event_clk_in : osc_clk_in;

    // Oscillation clock edges brought into the system clock domain
    rfcs_sync_edge u_src_sync
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in(count_src),
        .level_out(src_level),
        .rise_out(src_rise)
    );

    // Divided operating clock turned into one-cycle ticks
    rfcs_sync_edge u_tb_sync
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in(divided_operating_clock),
        .level_out(),
        .rise_out(tb_rise)
    );

    // Phase decode
    assign running = state_reg.phase != rfcs_pkg::RFCS_IDLE;
    assign in_ref = state_reg.phase == rfcs_pkg::RFCS_REF;
    assign in_sensor = (state_reg.phase == rfcs_pkg::RFCS_SENSOR_A)
                       || (state_reg.phase == rfcs_pkg::RFCS_SENSOR_B);

    // Start requests taken only from idle with the converter enabled
    assign start_ref = trig_wr && !running && converter_enable
                       && trig_wdata.reference_start_bit;
    assign start_a = trig_wr && !running && converter_enable
                     && !trig_wdata.reference_start_bit && trig_wdata.sensor_a_start_bit;
    assign start_b = trig_wr && !running && converter_enable
                     && !trig_wdata.reference_start_bit && !trig_wdata.sensor_a_start_bit
                     && trig_wdata.sensor_b_start_bit;

    // Zero written to the bit of the running phase
    always_comb
    begin
        abort_req = 1'b0;
        if (trig_wr)
        begin
            case (state_reg.phase)
                rfcs_pkg::RFCS_REF: abort_req = !trig_wdata.reference_start_bit;
                rfcs_pkg::RFCS_SENSOR_A: abort_req = !trig_wdata.sensor_a_start_bit;
                rfcs_pkg::RFCS_SENSOR_B: abort_req = !trig_wdata.sensor_b_start_bit;
                default: abort_req = 1'b0;
            endcase
        end
    end

    // Counter steering; counters freeze when no phase runs
    assign mc_up = running && src_rise;
    assign tc_up = in_ref && tb_rise;
    assign tc_is_zero = time_base_counter == rfcs_pkg::RFCS_CNT_ZERO;
    assign tc_down = in_sensor && tb_rise && !tc_is_zero;

    // Reference start forces the time base to zero
    assign tc_load = tc_wr || start_ref;
    assign tc_load_value = start_ref ? rfcs_pkg::RFCS_CNT_ZERO : tc_wdata;

    rfcs_counter #(.W(CNT_W)) u_measure_cnt
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .load(mc_wr),
        .load_value(mc_wdata),
        .count_up(mc_up),
        .count_down(1'b0),
        .value(measurement_counter),
        .wrap_up(mc_wrap),
        .reach_zero()
    );

    rfcs_counter #(.W(CNT_W)) u_time_base_cnt
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .load(tc_load),
        .load_value(tc_load_value),
        .count_up(tc_up),
        .count_down(tc_down),
        .value(time_base_counter),
        .wrap_up(tc_wrap),
        .reach_zero(tc_reach_zero)
    );

    // End causes for each phase
    assign ref_mc_end = in_ref && mc_wrap;
    assign ref_tc_end = in_ref && tc_wrap;
    assign sen_tc_end = in_sensor && (tc_reach_zero || tc_is_zero);
    assign sen_mc_end = in_sensor && mc_wrap;

    // Continuous mode suppresses every automatic stop
    assign auto_stop = !continuous_oscillation_enable
                       && (ref_mc_end || ref_tc_end || sen_tc_end || sen_mc_end);

    // Flag set causes, only when the phase really ends
    always_comb
    begin
        flag_set = rfcs_pkg::RFCS_FLAGS_RESET;
        if (!continuous_oscillation_enable)
        begin
            flag_set.reference_done_flag = ref_mc_end;
            flag_set.time_base_overflow_flag = ref_tc_end;
            flag_set.sensor_a_done_flag = sen_tc_end
                && (state_reg.phase == rfcs_pkg::RFCS_SENSOR_A);
            flag_set.sensor_b_done_flag = sen_tc_end
                && (state_reg.phase == rfcs_pkg::RFCS_SENSOR_B);
            flag_set.measure_overflow_flag = sen_mc_end;
        end
    end

    // Write-one-to-clear mask, applied only on a clear strobe
    assign flag_keep = flag_clr ? rfcs_pkg::rfcs_flags_type'(~flag_clr_mask)
                                : rfcs_pkg::rfcs_flags_type'({$bits(flag_keep){1'b1}});

    // Sequencer and flag update
    always_comb
    begin
        state_next = state_reg;
        // Set wins over a clear in the same cycle
        state_next.flags = rfcs_pkg::rfcs_flags_type'(
            (state_reg.flags & flag_keep) | flag_set);
        state_next.monitor = running && src_level;
        case (state_reg.phase)
            rfcs_pkg::RFCS_IDLE:
            begin
                state_next.trig = rfcs_pkg::RFCS_TRIG_RESET;
                if (start_ref)
                begin
                    state_next.phase = rfcs_pkg::RFCS_REF;
                    state_next.trig.reference_start_bit = 1'b1;
                end
                else if (start_a)
                begin
                    state_next.phase = rfcs_pkg::RFCS_SENSOR_A;
                    state_next.trig.sensor_a_start_bit = 1'b1;
                end
                else if (start_b)
                begin
                    state_next.phase = rfcs_pkg::RFCS_SENSOR_B;
                    state_next.trig.sensor_b_start_bit = 1'b1;
                end
            end
            rfcs_pkg::RFCS_REF,
            rfcs_pkg::RFCS_SENSOR_A,
            rfcs_pkg::RFCS_SENSOR_B:
            begin
                // Any stop leaves the counters holding their values
                if (abort_req || auto_stop || !converter_enable)
                begin
                    state_next.phase = rfcs_pkg::RFCS_IDLE;
                    state_next.trig = rfcs_pkg::RFCS_TRIG_RESET;
                end
            end
            default:
            begin
                state_next.phase = rfcs_pkg::RFCS_IDLE;
                state_next.trig = rfcs_pkg::RFCS_TRIG_RESET;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_reg.phase <= rfcs_pkg::RFCS_IDLE;
            state_reg.trig <= rfcs_pkg::RFCS_TRIG_RESET;
            state_reg.flags <= rfcs_pkg::RFCS_FLAGS_RESET;
            state_reg.monitor <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Register-driven outputs
    assign trig_status = state_reg.trig;
    assign flags = state_reg.flags;
    assign osc_clk_monitor = state_reg.monitor;

    // Enabled flags merged into one request line
    assign irq = |(state_reg.flags & flag_irq_enable);

endmodule : rfcs_core

// *** dv/rfcs_core_props.sv ***
`timescale 1ns/100ps

// Port-level checks of the counter and sequencing core
module rfcs_core_props
#(
    parameter int CNT_W = 24
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic converter_enable,
    input wire logic continuous_oscillation_enable,
    input wire logic trig_wr,
    input wire rfcs_pkg::rfcs_trig_type trig_wdata,
    input wire logic mc_wr,
    input wire logic tc_wr,
    input wire logic flag_clr,
    input wire rfcs_pkg::rfcs_flags_type flag_clr_mask,
    input wire rfcs_pkg::rfcs_flags_type flag_irq_enable,
    input wire rfcs_pkg::rfcs_trig_type trig_status,
    input wire rfcs_pkg::rfcs_flags_type flags,
    input wire logic [CNT_W-1:0] measurement_counter,
    input wire logic [CNT_W-1:0] time_base_counter,
    input wire logic irq
);
    localparam logic [CNT_W-1:0] all_ones = '1;
    logic [2:0] ph_reg;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Phase of last cycle when no write, abort or free run could interfere
    always_ff @(posedge clk_sys or posedge rst)
        if (rst)
            ph_reg <= 3'h0;
        else
            ph_reg <= (converter_enable && !continuous_oscillation_enable && !trig_wr
                && !mc_wr && !tc_wr) ? trig_status : 3'h0;
    a_ref_start: assert property (
        trig_wr && trig_wdata == 3'h4 && trig_status == 3'h0 && converter_enable && !tc_wr
        |=> trig_status == 3'h4 && time_base_counter == '0) else $error("ref start lost");
    a_enable_abort: assert property (
        !converter_enable && trig_status != 3'h0 |=> trig_status == 3'h0)
        else $error("disable did not stop phase");
    a_ref_done: assert property (
        ph_reg == 3'h4 && $past(measurement_counter) == all_ones && measurement_counter == '0
        |-> flags.reference_done_flag && trig_status == 3'h0) else $error("ref end wrong");
    a_tc_overflow: assert property (
        ph_reg == 3'h4 && $past(time_base_counter) == all_ones && time_base_counter == '0
        |-> flags.time_base_overflow_flag && trig_status == 3'h0) else $error("tc wrap wrong");
    a_sensor_done: assert property (
        (ph_reg == 3'h2 || ph_reg == 3'h1) && $past(time_base_counter) == 1 && time_base_counter == '0
        |-> trig_status == 3'h0 && (ph_reg == 3'h2 ? flags.sensor_a_done_flag
        : flags.sensor_b_done_flag)) else $error("sensor end wrong");
    a_mc_overflow: assert property (
        (ph_reg == 3'h2 || ph_reg == 3'h1) && $past(measurement_counter) == all_ones
        && measurement_counter == '0 |-> flags.measure_overflow_flag && trig_status == 3'h0)
        else $error("mc wrap wrong");
    a_tc_up: assert property (
        ph_reg == 3'h4 && trig_status == 3'h4 |-> time_base_counter == $past(time_base_counter)
        || time_base_counter == $past(time_base_counter) + 1) else $error("tc not counting up");
    a_mc_up: assert property (
        ph_reg != 3'h0 && trig_status == ph_reg |-> measurement_counter == $past(measurement_counter)
        || measurement_counter == $past(measurement_counter) + 1) else $error("mc step wrong");
    a_idle_hold: assert property (
        trig_status == 3'h0 && !mc_wr && !tc_wr && !trig_wr
        |=> $stable(measurement_counter) && $stable(time_base_counter)) else $error("idle count");
    a_flag_clear: assert property (
        flag_clr && flag_clr_mask == 5'h1f && trig_status == 3'h0 |=> flags == 5'h00)
        else $error("flags not cleared");
    a_irq_merge: assert property (
        irq == |(flags & flag_irq_enable)) else $error("irq mismatch");
    c_ref_done: cover property ($rose(flags.reference_done_flag));
    c_sensor_a: cover property ($rose(flags.sensor_a_done_flag));
    c_tc_ovf: cover property ($rose(flags.time_base_overflow_flag));
endmodule : rfcs_core_props

bind rfcs_core rfcs_core_props #(.CNT_W(CNT_W)) u_props (.clk_sys, .rst, .converter_enable,
    .continuous_oscillation_enable, .trig_wr, .trig_wdata, .mc_wr, .tc_wr, .flag_clr,
    .flag_clr_mask, .flag_irq_enable, .trig_status, .flags, .measurement_counter,
    .time_base_counter, .irq);

// *** dv/rfcs_osc_model.sv ***
`timescale 1ns/100ps

// Oscillator network: CR oscillator or external pulse source
module rfcs_osc_model
#(
    parameter int HALF = 2
)
(
    input wire logic clk_sys,
    input wire logic run,
    input wire logic ext_mode,
    output logic osc_clk_in,
    output logic event_clk_in
);
    int cnt = 0;
    logic wave = 1'b0;
    // Oscillates only while a phase runs, rests low otherwise
    always @(negedge clk_sys)
    begin
        if (!run)
        begin
            cnt <= 0;
            wave <= 1'b0;
        end
        else if (cnt == HALF - 1)
        begin
            cnt <= 0;
            wave <= !wave;
        end
        else
            cnt <= cnt + 1;
    end
    // Only the selected source toggles
    assign osc_clk_in = wave && !ext_mode;
    assign event_clk_in = wave && ext_mode;
endmodule : rfcs_osc_model

// *** dv/tb.sv ***
`timescale 1ns/100ps

// Self-checking bench of the counter and sequencing core
module tb;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic converter_enable = 1'b0;
    logic continuous_oscillation_enable = 1'b0;
    logic event_counter_select = 1'b0;
    logic divided_operating_clock = 1'b0;
    logic trig_wr = 1'b0;
    rfcs_pkg::rfcs_trig_type trig_wdata = 3'h0;
    logic mc_wr = 1'b0;
    logic [23:0] mc_wdata = 24'h000000;
    logic tc_wr = 1'b0;
    logic [23:0] tc_wdata = 24'h000000;
    logic flag_clr = 1'b0;
    rfcs_pkg::rfcs_flags_type flag_clr_mask = 5'h00;
    rfcs_pkg::rfcs_flags_type flag_irq_enable = 5'h00;
    logic osc_clk_in;
    logic event_clk_in;
    rfcs_pkg::rfcs_trig_type trig_status;
    rfcs_pkg::rfcs_flags_type flags;
    logic [23:0] measurement_counter;
    logic [23:0] time_base_counter;
    logic irq;
    logic osc_clk_monitor;
    logic [23:0] held_mc;
    logic [23:0] held_tc;
    int fail_count = 0;
    int checks_done = 0;
    int cycles = 0;
    rfcs_core u_dut (.clk_sys, .rst, .converter_enable, .continuous_oscillation_enable,
        .event_counter_select, .osc_clk_in, .event_clk_in, .divided_operating_clock, .trig_wr,
        .trig_wdata, .mc_wr, .mc_wdata, .tc_wr, .tc_wdata, .flag_clr, .flag_clr_mask,
        .flag_irq_enable, .trig_status, .flags, .measurement_counter, .time_base_counter,
        .osc_clk_monitor(osc_clk_monitor), .irq);
    rfcs_osc_model #(.HALF(2)) u_osc (.clk_sys, .run(trig_status != 3'h0),
        .ext_mode(event_counter_select), .osc_clk_in, .event_clk_in);
    always #4 clk_sys = !clk_sys;
    // Free-running divided clock, one tick every 6 cycles
    always
    begin
        repeat (3) @(negedge clk_sys);
        divided_operating_clock = !divided_operating_clock;
    end
    // Cut a hang short
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            $display("ERROR %0t timeout", $time);
            final_report();
        end
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report
    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1)
        begin
            fail_count++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask : chk
    // Clear all flags, optionally preset both counters, in one cycle
    task automatic prep(input logic [23:0] mcv, input logic [23:0] tcv, input logic load);
        mc_wr = load;
        mc_wdata = mcv;
        tc_wr = load;
        tc_wdata = tcv;
        flag_clr = 1'b1;
        flag_clr_mask = 5'h1f;
        @(negedge clk_sys);
        mc_wr = 1'b0;
        tc_wr = 1'b0;
        flag_clr = 1'b0;
    endtask : prep
    task automatic start(input logic [2:0] t);
        trig_wr = 1'b1;
        trig_wdata = t;
        @(negedge clk_sys);
        trig_wr = 1'b0;
    endtask : start
    task automatic wait_idle;
        for (int i = 0; i < 400 && trig_status !== 3'h0; i++)
            @(negedge clk_sys);
        chk(trig_status === 3'h0, "phase did not end");
    endtask : wait_idle
    task automatic t_ref_done;
        prep(24'hfffff0, 24'h000000, 1'b1);
        start(3'h4);
        chk(trig_status === 3'h4 && time_base_counter === 24'h000000, "ref start");
        wait_idle();
        chk(flags === 5'h10 && measurement_counter === 24'h000000, "ref done");
        chk(time_base_counter > 24'h000004, "ref duration");
        flag_irq_enable = 5'h10;
        #1 chk(irq === 1'b1, "irq not raised");
        flag_irq_enable = 5'h0f;
        #1 chk(irq === 1'b0, "irq not masked");
    endtask : t_ref_done
    task automatic t_sensor_a;
        prep(24'h000000, 24'h000000, 1'b0);
        chk(flags === 5'h00, "flags not cleared");
        start(3'h2);
        chk(trig_status === 3'h2, "sensor a start");
        wait_idle();
        chk(flags === 5'h08 && time_base_counter === 24'h000000, "sensor a done");
        chk(measurement_counter > 24'h00000c && measurement_counter < 24'h000014, "m vs n");
    endtask : t_sensor_a
    task automatic t_sensor_b_event;
        event_counter_select = 1'b1;
        prep(24'hfffff8, 24'h00ffff, 1'b1);
        start(3'h1);
        chk(trig_status === 3'h1, "sensor b start");
        wait_idle();
        chk(flags === 5'h02 && measurement_counter === 24'h000000, "mc overflow");
        // Short sensor B run that ends on the time base reaching zero
        prep(24'h000000, 24'h000003, 1'b1);
        start(3'h1);
        wait_idle();
        chk(flags === 5'h04 && time_base_counter === 24'h000000, "sensor b done");
        event_counter_select = 1'b0;
    endtask : t_sensor_b_event
    task automatic t_tc_ovf;
        prep(24'h000000, 24'h000000, 1'b1);
        start(3'h4);
        tc_wr = 1'b1;
        tc_wdata = 24'hfffffe;
        @(negedge clk_sys);
        tc_wr = 1'b0;
        wait_idle();
        chk(flags === 5'h01 && time_base_counter === 24'h000000, "tc overflow");
    endtask : t_tc_ovf
    task automatic t_abort;
        prep(24'h000000, 24'h000100, 1'b1);
        start(3'h2);
        repeat (40) @(negedge clk_sys);
        start(3'h0);
        chk(trig_status === 3'h0, "abort");
        held_mc = measurement_counter;
        held_tc = time_base_counter;
        repeat (20) @(negedge clk_sys);
        chk(measurement_counter === held_mc && held_mc !== 24'h000000, "mc hold");
        chk(time_base_counter === held_tc && held_tc < 24'h000100, "tc hold");
        start(3'h4);
        converter_enable = 1'b0;
        @(negedge clk_sys);
        chk(trig_status === 3'h0, "disable abort");
        start(3'h4);
        chk(trig_status === 3'h0, "start while disabled");
        converter_enable = 1'b1;
    endtask : t_abort
    task automatic t_continuous;
        int seen;
        seen = 0;
        continuous_oscillation_enable = 1'b1;
        prep(24'hfffff8, 24'h000000, 1'b1);
        start(3'h4);
        // Monitor output must follow the oscillation while running
        for (int i = 0; i < 80; i++)
        begin
            @(negedge clk_sys);
            if (osc_clk_monitor === 1'b1)
                seen++;
        end
        chk(trig_status === 3'h4 && flags === 5'h00, "continuous stopped");
        chk(seen > 0 && seen < 80, "monitor not toggling");
        start(3'h0);
        @(negedge clk_sys);
        chk(osc_clk_monitor === 1'b0, "monitor active while idle");
        continuous_oscillation_enable = 1'b0;
    endtask : t_continuous
    initial
    begin
        repeat (3) @(negedge clk_sys);
        rst = 1'b0;
        converter_enable = 1'b1;
        @(negedge clk_sys);
        t_ref_done();
        t_sensor_a();
        t_sensor_b_event();
        t_tc_ovf();
        t_abort();
        t_continuous();
        final_report();
    end
endmodule : tb
